// ==== test/dsau_access_unit_bench.sv ====
/*
 * Self-checking bench for the data-space access unit.
 * Assumes the SFR model on the peripheral port; inputs change on falling edges.
 */
`timescale 1ns/1ps
module dsau_access_unit_bench;
  import dsau_pkg::*;
  logic clk_sys = 0, rstn = 0, req_valid = 0, req_write = 0, req_byte = 0, req_load_wreg = 0;
  logic sign_extend_op = 0, zero_extend_op = 0, instr_end = 0;
  dsau_mode_t req_mode = MODE_NEAR;
  logic [12:0] near_field = 13'h0000;
  logic [15:0] move_field = 16'h0000, source_pointer_reg = 16'h0000, req_wdata = 16'h0000;
  logic [15:0] wreg_value = 16'h0000, sfr_rdata, sfr_bit_mask, rdata, effective_address, ptr_wdata;
  logic [15:0] wreg_wdata, sfr_addr, sfr_wdata;
  logic req_ready, done, ptr_we, wreg_we_lo, wreg_we_hi, sfr_we_lo, sfr_we_hi, sfr_re, addr_error_trap;
  int fails = 0, checks = 0;
  always #50 clk_sys = ~clk_sys;
  dsau_access_unit dsau_access_unit_i (.clk_sys, .rstn, .req_valid, .req_write, .req_byte, .req_mode,
    .near_field, .move_field, .source_pointer_reg, .req_wdata, .req_load_wreg, .sign_extend_op,
    .zero_extend_op, .wreg_value, .instr_end, .sfr_rdata, .sfr_bit_mask, .req_ready, .done, .rdata,
    .effective_address, .ptr_wdata, .ptr_we, .wreg_wdata, .wreg_we_lo, .wreg_we_hi, .sfr_addr, .sfr_wdata,
    .sfr_we_lo, .sfr_we_hi, .sfr_re, .addr_error_trap);
  dsau_sfr_model dsau_sfr_model_i (.clk_sys, .sfr_addr, .sfr_wdata, .sfr_we_lo, .sfr_we_hi, .sfr_re,
    .sfr_rdata, .sfr_bit_mask);
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic close_out();
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic b, input dsau_mode_t m, input logic [15:0] a,
    input logic [15:0] d, input logic ld);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_write = w;
    req_byte = b;
    req_mode = m;
    req_load_wreg = ld;
    req_wdata = d;
    near_field = a[12:0];
    move_field = a;
    source_pointer_reg = a;
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
    if (n == 8) close_out();
  endtask : acc
  task automatic rd(input logic b, input dsau_mode_t m, input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, b, m, a, 16'h0000, 1'b0);
    chk("rdata", e, rdata);
  endtask : rd
  task automatic trap_seen();
    int n;
    @(negedge clk_sys);
    instr_end = 1'b1;
    @(negedge clk_sys);
    instr_end = 1'b0;
    n = 0;
    while (addr_error_trap !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    chk("trap", 16'h0001, {15'h0000, addr_error_trap});
    if (n == 4) close_out();
    @(negedge clk_sys);
    chk("trap end", 16'h0000, {15'h0000, addr_error_trap});
  endtask : trap_seen
  task automatic ext(input logic s, input logic [15:0] v, input logic [15:0] e);
    @(negedge clk_sys);
    sign_extend_op = s;
    zero_extend_op = ~s;
    wreg_value = v;
    @(negedge clk_sys);
    sign_extend_op = 1'b0;
    zero_extend_op = 1'b0;
    chk("extend", e, wreg_wdata);
    chk("extend strobes", 16'h0003, {14'h0000, wreg_we_hi, wreg_we_lo});
  endtask : ext
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_ram_lanes();
    acc(1'b1, 1'b0, MODE_NEAR, 16'h0900, 16'hA5C3, 1'b0);
    acc(1'b1, 1'b1, MODE_NEAR, 16'h0901, 16'h0077, 1'b0);
    rd(1'b0, MODE_NEAR, 16'h0900, 16'h77C3);
    acc(1'b0, 1'b1, MODE_NEAR, 16'h0901, 16'h0000, 1'b1);
    chk("byte hi", 16'h0077, rdata);
    chk("wreg strobes", 16'h0001, {14'h0000, wreg_we_hi, wreg_we_lo});
    rd(1'b1, MODE_NEAR, 16'h0900, 16'h00C3);
  endtask : t_ram_lanes
  task automatic t_post_inc();
    rd(1'b1, MODE_IND_POST, 16'h0900, 16'h00C3);
    chk("ptr byte", 16'h0901, ptr_wdata);
    rd(1'b0, MODE_IND_POST, 16'h0900, 16'h77C3);
    chk("ptr word", 16'h0902, ptr_wdata);
  endtask : t_post_inc
  task automatic t_misaligned();
    acc(1'b1, 1'b0, MODE_MOVE, 16'h0902, 16'h1111, 1'b0);
    acc(1'b1, 1'b0, MODE_MOVE, 16'h0903, 16'hFFFF, 1'b0);
    trap_seen();
    rd(1'b0, MODE_NEAR, 16'h0902, 16'h1111);
    rd(1'b0, MODE_IND, 16'h0901, 16'h77C3);
    trap_seen();
  endtask : t_misaligned
  task automatic t_sfr();
    acc(1'b1, 1'b0, MODE_NEAR, 16'h0104, 16'h1234, 1'b0);
    rd(1'b0, MODE_NEAR, 16'h0104, 16'h0034);
    acc(1'b1, 1'b0, MODE_NEAR, 16'h0105, 16'hFFFF, 1'b0);
    trap_seen();
    rd(1'b0, MODE_NEAR, 16'h0104, 16'h0034);
    acc(1'b1, 1'b0, MODE_NEAR, 16'h0100, 16'hBEEF, 1'b0);
    acc(1'b1, 1'b1, MODE_NEAR, 16'h0101, 16'h00AB, 1'b0);
    rd(1'b0, MODE_NEAR, 16'h0100, 16'hABEF);
    rd(1'b0, MODE_NEAR, 16'h0400, 16'h0000);
  endtask : t_sfr
  task automatic t_far();
    acc(1'b1, 1'b0, MODE_MOVE, 16'h2000, 16'h5A5A, 1'b0);
    rd(1'b0, MODE_MOVE, 16'h2000, 16'h5A5A);
    chk("ea move", 16'h2000, effective_address);
    acc(1'b1, 1'b0, MODE_NEAR, 16'h1FFE, 16'h3C3C, 1'b0);
    rd(1'b0, MODE_NEAR, 16'h1FFE, 16'h3C3C);
    chk("ea near", 16'h1FFE, effective_address);
  endtask : t_far
  task automatic t_extend();
    ext(1'b1, 16'h1280, 16'hFF80);
    ext(1'b0, 16'hAB80, 16'h0080);
  endtask : t_extend
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (5) @(negedge clk_sys);
    t_ram_lanes();
    t_post_inc();
    t_misaligned();
    t_sfr();
    t_far();
    t_extend();
    close_out();
  end
endmodule : dsau_access_unit_bench

// ==== test/dsau_access_unit_checker.sv ====
/*
 * Checker for the data-space access unit, bound to its top module.
 * Assumes clk_sys as the only clock and requests taken only while req_ready is high.
 */
`timescale 1ns/1ps
module dsau_access_unit_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_byte,
  input wire dsau_pkg::dsau_mode_t req_mode,
  input wire logic [12:0] near_field,
  input wire logic [15:0] move_field,
  input wire logic [15:0] source_pointer_reg,
  input wire logic req_load_wreg,
  input wire logic sign_extend_op,
  input wire logic zero_extend_op,
  input wire logic [15:0] wreg_value,
  input wire logic instr_end,
  input wire logic req_ready,
  input wire logic done,
  input wire logic [15:0] rdata,
  input wire logic [15:0] effective_address,
  input wire logic [15:0] ptr_wdata,
  input wire logic ptr_we,
  input wire logic [15:0] wreg_wdata,
  input wire logic wreg_we_lo,
  input wire logic wreg_we_hi,
  input wire logic sfr_we_lo,
  input wire logic sfr_we_hi,
  input wire logic addr_error_trap
);
  import dsau_pkg::*;
  // ************************************************************
  // Helpers and assertions
  // ************************************************************
  logic take;
  logic [15:0] wv_q;
  assign take = req_valid && req_ready;
  always_ff @(posedge clk_sys) wv_q <= wreg_value;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_trap_single: assert property (addr_error_trap |=> !addr_error_trap)
    else $error("trap held longer than one cycle");
  a_trap_at_end: assert property ($rose(addr_error_trap) |-> $past(instr_end))
    else $error("trap not aligned to instruction end");
  a_post_inc_step: assert property (take && req_mode == MODE_IND_POST |=> ptr_we &&
    ptr_wdata == $past(source_pointer_reg) + ($past(req_byte) ? STEP_BYTE : STEP_WORD))
    else $error("pointer step wrong");
  a_near_field_ea: assert property (take && req_mode == MODE_NEAR |=>
    effective_address == {3'h0, $past(near_field)}) else $error("near address wrong");
  a_move_full_ea: assert property (take && req_mode == MODE_MOVE |=>
    effective_address == $past(move_field)) else $error("move address wrong");
  a_read_completes: assert property (take && !req_write |-> ##3 done)
    else $error("read did not complete");
  a_byte_read_low: assert property (take && !req_write && req_byte |-> ##3 rdata[15:8] == 8'h00)
    else $error("byte read upper half not clear");
  a_byte_load_lo: assert property (take && !req_write && req_byte && req_load_wreg |->
    ##3 wreg_we_lo && !wreg_we_hi) else $error("byte load strobes wrong");
  a_byte_one_strobe: assert property ((sfr_we_lo || sfr_we_hi) && $past(req_byte) |->
    sfr_we_lo != sfr_we_hi) else $error("byte write strobes wrong");
  a_word_both_strobes: assert property ((sfr_we_lo || sfr_we_hi) && !$past(req_byte) |->
    sfr_we_lo && sfr_we_hi) else $error("word write strobes wrong");
  a_misaligned_write: assert property (take && req_write && !req_byte ##1 effective_address[0] |->
    !(sfr_we_lo || sfr_we_hi) [*3]) else $error("misaligned write not suppressed");
  a_sign_extend: assert property (req_ready && !req_valid && sign_extend_op |=> wreg_we_lo &&
    wreg_we_hi && wreg_wdata == {{8{wv_q[7]}}, wv_q[7:0]}) else $error("sign extend wrong");
  a_zero_extend: assert property (req_ready && !req_valid && !sign_extend_op && zero_extend_op |=>
    wreg_wdata == {8'h00, wv_q[7:0]}) else $error("zero extend wrong");
  a_ready_busy: assert property (take |=> !req_ready [*2] ##1 req_ready)
    else $error("ready timing wrong");
  c_trap: cover property (addr_error_trap);
  c_post_inc: cover property (take && req_mode == MODE_IND_POST);
  c_byte_hi: cover property (sfr_we_hi && !sfr_we_lo);
endmodule : dsau_access_unit_checker

bind dsau_access_unit dsau_access_unit_checker chk_i (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
  .req_write(req_write), .req_byte(req_byte), .req_mode(req_mode), .near_field(near_field),
  .move_field(move_field), .source_pointer_reg(source_pointer_reg), .req_load_wreg(req_load_wreg),
  .sign_extend_op(sign_extend_op), .zero_extend_op(zero_extend_op), .wreg_value(wreg_value),
  .instr_end(instr_end), .req_ready(req_ready), .done(done), .rdata(rdata), .effective_address(effective_address),
  .ptr_wdata(ptr_wdata), .ptr_we(ptr_we), .wreg_wdata(wreg_wdata), .wreg_we_lo(wreg_we_lo),
  .wreg_we_hi(wreg_we_hi), .sfr_we_lo(sfr_we_lo), .sfr_we_hi(sfr_we_hi), .addr_error_trap(addr_error_trap));

// ==== test/dsau_sfr_model.sv ====
/*
 * Peripheral side model: sixteen registers behind the SFR port.
 * Assumes read data are wanted in the cycle sfr_re is high.
 */
`timescale 1ns/1ps
module dsau_sfr_model (
  input wire logic clk_sys,
  input wire logic [15:0] sfr_addr,
  input wire logic [15:0] sfr_wdata,
  input wire logic sfr_we_lo,
  input wire logic sfr_we_hi,
  input wire logic sfr_re,
  output logic [15:0] sfr_rdata,
  output logic [15:0] sfr_bit_mask
);
  logic [15:0] regs [16];
  logic [15:0] last_q = 16'h0000;
  initial foreach (regs[i]) regs[i] = 16'h0000;
  always @(posedge clk_sys) begin
    if (sfr_we_lo) regs[sfr_addr[4:1]][7:0] <= sfr_wdata[7:0];
    if (sfr_we_hi) regs[sfr_addr[4:1]][15:8] <= sfr_wdata[15:8];
    if (sfr_re) last_q <= sfr_rdata;
  end
  // Outside a read the bus shows the inverse of the last value
  always_comb begin
    sfr_rdata = sfr_re ? regs[sfr_addr[4:1]] : ~last_q;
    sfr_bit_mask = sfr_re ? (sfr_addr[2] ? 16'h00FF : 16'hFFFF) : 16'h5A5A;
  end
endmodule : dsau_sfr_model

// ==== verilog/dsau_access_unit.sv ====
/*
 * Data-space access unit: address generation, byte lane steering,
 * misaligned word detection with address error trap, SFR window decode
 * and the data RAM behind it.
 * Assumes the core drives requests on clk_sys and marks instruction end.
 */
// Summary of operation
// - Post-increment adds one for byte, two for word
// - Byte read fetches word, address bit zero selects
// - Selected byte delivered on low eight bits
// - Shared word decode, separate byte write strobes
// - Odd-address word access raises address error trap
// - Misaligned read completes before trap is taken
// - Misaligned write executes but write is suppressed
// - Byte load writes only working register low byte
// - Sign-extend turns 8-bit into 16-bit signed
// - Zero-extend clears working register upper byte
// - Near space reached by 13-bit direct field
// - Move reaches whole space with 16-bit field
// - Addresses 0000h to 07FFh form SFR window
// - Unused SFR window addresses read as zero
// - SFR regions decoded in 32-byte granularity
// - Unimplemented SFR bits read as zero
`timescale 1ns/1ps
module dsau_access_unit #(
  parameter int RAM_DEPTH = 4096,
  parameter int RAM_AW = 12,
  parameter logic [63:0] REGION_MAP = dsau_pkg::SFR_REGION_MAP
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_byte,
  input wire dsau_pkg::dsau_mode_t req_mode,
  input wire logic [dsau_pkg::NEAR_FIELD_W-1:0] near_field,
  input wire logic [dsau_pkg::ADDR_W-1:0] move_field,
  input wire logic [dsau_pkg::DATA_W-1:0] source_pointer_reg,
  input wire logic [dsau_pkg::DATA_W-1:0] req_wdata,
  input wire logic req_load_wreg,
  input wire logic sign_extend_op,
  input wire logic zero_extend_op,
  input wire logic [dsau_pkg::DATA_W-1:0] wreg_value,
  input wire logic instr_end,
  input wire logic [dsau_pkg::DATA_W-1:0] sfr_rdata,
  input wire logic [dsau_pkg::DATA_W-1:0] sfr_bit_mask,
  output logic req_ready,
  output logic done,
  output logic [dsau_pkg::DATA_W-1:0] rdata,
  output logic [dsau_pkg::ADDR_W-1:0] effective_address,
  output logic [dsau_pkg::DATA_W-1:0] ptr_wdata,
  output logic ptr_we,
  output logic [dsau_pkg::DATA_W-1:0] wreg_wdata,
  output logic wreg_we_lo,
  output logic wreg_we_hi,
  output logic [dsau_pkg::ADDR_W-1:0] sfr_addr,
  output logic [dsau_pkg::DATA_W-1:0] sfr_wdata,
  output logic sfr_we_lo,
  output logic sfr_we_hi,
  output logic sfr_re,
  output logic addr_error_trap
);
  import dsau_pkg::*;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic in_sfr_window(input logic [15:0] a);
    in_sfr_window = (a <= SFR_WINDOW_LAST);
  endfunction : in_sfr_window

  function automatic logic region_used(input logic [15:0] a, input logic [63:0] map);
    region_used = map[a[SFR_REGION_MSB:SFR_REGION_LSB]];
  endfunction : region_used

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_sync1_reg, rst_sync2_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  logic rst_n_int;
  assign rst_n_int = rst_sync2_reg;

  // ************************************************************
  // State
  // ************************************************************
  dsau_state_t state_reg, state_next;
  logic [15:0] ea_reg, ea_next, wdata_reg, wdata_next, sfr_hold_reg, sfr_hold_next;
  logic byte_reg, byte_next, write_reg, write_next, load_reg, load_next;
  logic sel_ram_reg, sel_ram_next, sel_sfr_reg, sel_sfr_next;
  logic ram_we_lo_reg, ram_we_lo_next, ram_we_hi_reg, ram_we_hi_next;
  logic pending_reg, pending_next, ready_reg, ready_next, done_reg, done_next;
  logic [15:0] rdata_reg, rdata_next, ptr_wdata_reg, ptr_wdata_next;
  logic ptr_we_reg, ptr_we_next;
  logic [15:0] wreg_wdata_reg, wreg_wdata_next;
  logic wreg_we_lo_reg, wreg_we_lo_next, wreg_we_hi_reg, wreg_we_hi_next;
  logic [15:0] sfr_addr_reg, sfr_addr_next, sfr_wdata_reg, sfr_wdata_next;
  logic sfr_we_lo_reg, sfr_we_lo_next, sfr_we_hi_reg, sfr_we_hi_next;
  logic sfr_re_reg, sfr_re_next, trap_reg, trap_next;

  // ************************************************************
  // Data RAM above the SFR window
  // ************************************************************
  logic [15:0] ram_off;
  logic [15:0] ram_rdata;
  logic ram_in_range;
  assign ram_off = ea_reg - RAM_BASE;
  assign ram_in_range = ({1'b0, ram_off[15:1]} < 16'(RAM_DEPTH));

  dsau_byte_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(RAM_AW)
  ) u_ram (
    .clk_sys(clk_sys),
    .addr(ram_off[RAM_AW:1]),
    .we_lo(ram_we_lo_reg && ram_in_range),
    .we_hi(ram_we_hi_reg && ram_in_range),
    .wdata(wdata_reg),
    .rdata(ram_rdata)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic [15:0] ea;
    logic misaligned;
    logic [15:0] word;
    logic [7:0] sel_byte;
    ea = WORD_RESET;
    misaligned = 1'b0;
    word = WORD_RESET;
    sel_byte = BYTE_ZERO;
    state_next = state_reg;
    ea_next = ea_reg;
    byte_next = byte_reg;
    write_next = write_reg;
    load_next = load_reg;
    sel_ram_next = sel_ram_reg;
    sel_sfr_next = sel_sfr_reg;
    ram_we_lo_next = 1'b0;
    ram_we_hi_next = 1'b0;
    wdata_next = wdata_reg;
    sfr_hold_next = sfr_hold_reg;
    pending_next = pending_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    ptr_wdata_next = ptr_wdata_reg;
    ptr_we_next = 1'b0;
    wreg_wdata_next = wreg_wdata_reg;
    wreg_we_lo_next = 1'b0;
    wreg_we_hi_next = 1'b0;
    sfr_addr_next = sfr_addr_reg;
    sfr_wdata_next = sfr_wdata_reg;
    sfr_we_lo_next = 1'b0;
    sfr_we_hi_next = 1'b0;
    sfr_re_next = 1'b0;
    trap_next = 1'b0;

    // Trap waits for the end of the faulting instruction
    if (instr_end && pending_reg) begin
      trap_next = 1'b1;
      pending_next = 1'b0;
    end

    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          case (req_mode)
            MODE_NEAR: ea = {3'b000, near_field};
            MODE_MOVE: ea = move_field;
            default: ea = source_pointer_reg;
          endcase
          if (req_mode == MODE_IND_POST) begin
            ptr_wdata_next = source_pointer_reg + (req_byte ? STEP_BYTE : STEP_WORD);
            ptr_we_next = 1'b1;
          end
          misaligned = !req_byte && ea[BYTE_LSB];
          if (misaligned) begin
            pending_next = 1'b1;
          end
          ea_next = ea;
          byte_next = req_byte;
          write_next = req_write;
          load_next = req_load_wreg && !req_write;
          sel_sfr_next = in_sfr_window(ea) && region_used(ea, REGION_MAP);
          sel_ram_next = !in_sfr_window(ea);
          wdata_next = req_byte ? {req_wdata[7:0], req_wdata[7:0]} : req_wdata;
          if (req_write && !misaligned) begin
            // Word sets both strobes, byte only the addressed half
            ram_we_lo_next = !in_sfr_window(ea) && (!req_byte || !ea[BYTE_LSB]);
            ram_we_hi_next = !in_sfr_window(ea) && (!req_byte || ea[BYTE_LSB]);
            sfr_we_lo_next = sel_sfr_next && (!req_byte || !ea[BYTE_LSB]);
            sfr_we_hi_next = sel_sfr_next && (!req_byte || ea[BYTE_LSB]);
          end
          // Misaligned write: strobes stay low, rest of instruction goes on
          sfr_re_next = sel_sfr_next && !req_write;
          sfr_addr_next = {ea[15:1], 1'b0};
          sfr_wdata_next = wdata_next;
          state_next = ST_ACCESS;
        end else if (sign_extend_op) begin
          wreg_wdata_next = {(wreg_value[SIGN_BIT] ? BYTE_ONES : BYTE_ZERO), wreg_value[7:0]};
          wreg_we_lo_next = 1'b1;
          wreg_we_hi_next = 1'b1;
          done_next = 1'b1;
        end else if (zero_extend_op) begin
          wreg_wdata_next = {BYTE_ZERO, wreg_value[7:0]};
          wreg_we_lo_next = 1'b1;
          wreg_we_hi_next = 1'b1;
          done_next = 1'b1;
        end
      end
      ST_ACCESS: begin
        sfr_hold_next = sfr_rdata & sfr_bit_mask;
        state_next = ST_MERGE;
      end
      ST_MERGE: begin
        if (sel_sfr_reg) begin
          word = sfr_hold_reg;
        end else if (sel_ram_reg && ram_in_range) begin
          word = ram_rdata;
        end else begin
          word = WORD_RESET;
        end
        sel_byte = ea_reg[BYTE_LSB] ? word[15:8] : word[7:0];
        if (!write_reg) begin
          rdata_next = byte_reg ? {BYTE_ZERO, sel_byte} : word;
          if (load_reg) begin
            wreg_wdata_next = rdata_next;
            wreg_we_lo_next = 1'b1;
            wreg_we_hi_next = !byte_reg;
          end
        end
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    ready_next = (state_next == ST_IDLE);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_reg <= ST_IDLE;
      ea_reg <= WORD_RESET;
      byte_reg <= 1'b0;
      write_reg <= 1'b0;
      load_reg <= 1'b0;
      sel_ram_reg <= 1'b0;
      sel_sfr_reg <= 1'b0;
      ram_we_lo_reg <= 1'b0;
      ram_we_hi_reg <= 1'b0;
      wdata_reg <= WORD_RESET;
      sfr_hold_reg <= WORD_RESET;
      pending_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= WORD_RESET;
      ptr_wdata_reg <= WORD_RESET;
      ptr_we_reg <= 1'b0;
      wreg_wdata_reg <= WORD_RESET;
      wreg_we_lo_reg <= 1'b0;
      wreg_we_hi_reg <= 1'b0;
      sfr_addr_reg <= WORD_RESET;
      sfr_wdata_reg <= WORD_RESET;
      sfr_we_lo_reg <= 1'b0;
      sfr_we_hi_reg <= 1'b0;
      sfr_re_reg <= 1'b0;
      trap_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ea_reg <= ea_next;
      byte_reg <= byte_next;
      write_reg <= write_next;
      load_reg <= load_next;
      sel_ram_reg <= sel_ram_next;
      sel_sfr_reg <= sel_sfr_next;
      ram_we_lo_reg <= ram_we_lo_next;
      ram_we_hi_reg <= ram_we_hi_next;
      wdata_reg <= wdata_next;
      sfr_hold_reg <= sfr_hold_next;
      pending_reg <= pending_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      ptr_wdata_reg <= ptr_wdata_next;
      ptr_we_reg <= ptr_we_next;
      wreg_wdata_reg <= wreg_wdata_next;
      wreg_we_lo_reg <= wreg_we_lo_next;
      wreg_we_hi_reg <= wreg_we_hi_next;
      sfr_addr_reg <= sfr_addr_next;
      sfr_wdata_reg <= sfr_wdata_next;
      sfr_we_lo_reg <= sfr_we_lo_next;
      sfr_we_hi_reg <= sfr_we_hi_next;
      sfr_re_reg <= sfr_re_next;
      trap_reg <= trap_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign req_ready = ready_reg;
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign effective_address = ea_reg;
  assign ptr_wdata = ptr_wdata_reg;
  assign ptr_we = ptr_we_reg;
  assign wreg_wdata = wreg_wdata_reg;
  assign wreg_we_lo = wreg_we_lo_reg;
  assign wreg_we_hi = wreg_we_hi_reg;
  assign sfr_addr = sfr_addr_reg;
  assign sfr_wdata = sfr_wdata_reg;
  assign sfr_we_lo = sfr_we_lo_reg;
  assign sfr_we_hi = sfr_we_hi_reg;
  assign sfr_re = sfr_re_reg;
  assign addr_error_trap = trap_reg;

endmodule : dsau_access_unit

// ==== verilog/dsau_byte_ram.sv ====
/*
 * Data RAM built as two parallel byte-wide arrays with one shared word
 * address and separate write strobes; read data come out of a register.
 * Assumes a single clock and synchronous write and read.
 */
`timescale 1ns/1ps
module dsau_byte_ram #(
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  input wire logic clk_sys,
  input wire logic [AW-1:0] addr,
  input wire logic we_lo,
  input wire logic we_hi,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  logic [7:0] mem_lo [DEPTH];
  logic [7:0] mem_hi [DEPTH];
  logic [15:0] rdata_reg;

  // ************************************************************
  // Byte lanes
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (we_lo) begin
      mem_lo[addr] <= wdata[7:0];
    end
    if (we_hi) begin
      mem_hi[addr] <= wdata[15:8];
    end
    rdata_reg <= {mem_hi[addr], mem_lo[addr]};
  end

  assign rdata = rdata_reg;

endmodule : dsau_byte_ram

// ==== verilog/dsau_pkg.sv ====
/*
 * Shared constants for the data-space access unit: address map,
 * access modes, state codes and field positions.
 * Assumes a 16-bit data path and a byte-addressed 64 KB data space.
 */
package dsau_pkg;

  // ************************************************************
  // Data path and address widths
  // ************************************************************
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int NEAR_FIELD_W = 13;
  localparam int BYTE_LSB = 0;
  localparam int SIGN_BIT = 7;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [15:0] NEAR_SPACE_LAST = 16'h1FFF;
  localparam logic [15:0] SFR_WINDOW_LAST = 16'h07FF;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam int SFR_REGION_LSB = 5;
  localparam int SFR_REGION_MSB = 10;
  localparam int SFR_REGION_CNT = 64;
  localparam logic [63:0] SFR_REGION_MAP = 64'h0CF7_0000_03DF_173F;

  // ************************************************************
  // Pointer steps
  // ************************************************************
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_NEAR = 2'b00,
    MODE_MOVE = 2'b01,
    MODE_IND = 2'b10,
    MODE_IND_POST = 2'b11
  } dsau_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_MERGE = 2'b10
  } dsau_state_t;

endpackage : dsau_pkg
